// ---- atfr_pkg.sv ----
// Shared constants of the task-file register block: addresses, bit positions,
// reset values and common types.
// Assumes both ends import it; no surroundings beyond the compiler.
package atfr_pkg;

  typedef logic [7:0]  atfr_byte_t;
  typedef logic [15:0] atfr_word_t;
  typedef logic [3:0]  atfr_addr_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses: bit 3 selects the control block
  localparam atfr_addr_t ADR_DATA = 4'h0;
  localparam atfr_addr_t ADR_FEAT = 4'h1;
  localparam atfr_addr_t ADR_SCNT = 4'h2;
  localparam atfr_addr_t ADR_SNUM = 4'h3;
  localparam atfr_addr_t ADR_CYLL = 4'h4;
  localparam atfr_addr_t ADR_CYLH = 4'h5;
  localparam atfr_addr_t ADR_DHS  = 4'h6;
  localparam atfr_addr_t ADR_CMD  = 4'h7;  // Command on write, status on read
  localparam atfr_addr_t ADR_CTL  = 4'hE;  // Drive control on write, shadow on read

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int DH_LBA_BIT  = 6;
  localparam int DH_DEV_BIT  = 4;
  localparam int DC_NIEN_BIT = 1;
  localparam int DC_SRST_BIT = 2;
  localparam int ST_BSY_BIT  = 7;
  localparam int ST_DRDY_BIT = 6;
  localparam int ST_DSC_BIT  = 4;
  localparam int ST_DRQ_BIT  = 3;
  localparam int ST_ERR_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam atfr_byte_t SCNT_RST = 8'h01;
  localparam atfr_byte_t SNUM_RST = 8'h01;
  localparam atfr_byte_t CYL_RST  = 8'h00;
  localparam atfr_byte_t DH_RST   = 8'hA0;
  localparam atfr_byte_t FEAT_RST = 8'h00;
  localparam atfr_byte_t DCTL_MASK = 8'h06;  // Only interrupt mask and reset bits
  localparam logic [8:0] SCNT_ZERO_SECTORS = 9'h100;
  localparam int POLL_LIMIT_DEF = 255;

  typedef enum logic {AM_CHS, AM_LBA} atfr_amode_e;

endpackage

// ---- atfr_if.sv ----
// Parallel host port between the host controller and the drive.
// Assumes both ends run on the same clock; the interrupt wire is resolved here.
`timescale 1ns/1ns
interface atfr_if;
  logic [3:0]  addr;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        dmack_n;
  logic        intrq_o;
  logic        intrq_oe_n;
  logic        intrq;

  // Released line reads low
  assign intrq = intrq_o & ~intrq_oe_n;

  modport dev  (input addr, wr_stb, rd_stb, wdata, dmack_n,
                output rdata, intrq_o, intrq_oe_n);
  modport host (output addr, wr_stb, rd_stb, wdata, dmack_n,
                input rdata, intrq);
endinterface

// ---- atfr_dev.sv ----
// Drive end of the task-file register set with its two-entry data buffers.
// Assumes a synchronous host strobing one register per cycle on the port,
// and a drive core on the user side that runs commands and moves sectors.
//
// Function
// - Cylinder low: cylinder bits 0-7 or LBA 8-15
// - Task-file writes only while BSY and DRQ clear
// - Cylinder high: bits 8-15/LBA 16-23, completion update
// - Drive/head bit 6 selects CHS or LBA
// - Drive/head bit 4 selects master or slave
// - CHS: bits 0-3 give starting head
// - LBA: bits 0-3 give LBA 24-27
// - Sector count zero means 256 sectors
// - Count decrements per sector, ends at zero
// - Data register is 16 bits wide
// - Data moves only while DRQ set
// - Shadow status mirrors status; BSY always valid (code returns 00h for status reads in sleep)
// - Registers need not be valid in sleep
// - Drive control written only with DMA acknowledge off
// - Control bit 1 masks interrupt, releases pin
// - Control bit 2 is software reset
// - Host writes control bit 0 as zero
// - DRQ set when a word can move
// - BSY while drive owns registers; ignore commands
// - LBA: sector number holds LBA 0-7
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer with valid and ready on both sides
module atfr_buf #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic          rdy_r, rdy_nxt, vld_r, vld_nxt;
  logic          push, pop;

  assign in_ready  = rdy_r;
  assign out_valid = vld_r;
  assign out_data  = mem_r[rp_r];

  // Pointer, count and storage update
  always_comb begin
    push    = in_valid & rdy_r;
    pop     = out_ready & vld_r;
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = (wp_r == LAST) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + 1'b1;
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    if (flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
    rdy_nxt = (cnt_nxt != FULL);
    vld_nxt = (cnt_nxt != '0);
  end

  // State registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      vld_r <= vld_nxt;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Drive end: registers, status, interrupt and data buffers
module atfr_dev (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  atfr_if.dev                       bus,
  output logic                      cmd_valid,
  output atfr_pkg::atfr_byte_t      cmd_code,
  output atfr_pkg::atfr_byte_t      feature,
  output atfr_pkg::atfr_amode_e     addr_mode,
  output logic                      dev_sel,
  output logic [3:0]                head_or_lba_hi,
  output atfr_pkg::atfr_byte_t      sector_num,
  output atfr_pkg::atfr_byte_t      cyl_low,
  output atfr_pkg::atfr_byte_t      cyl_high,
  output logic [8:0]                sectors_left,
  output logic                      soft_reset,
  input  wire logic                 core_busy,
  input  wire logic                 core_drdy,
  input  wire logic                 core_dsc,
  input  wire logic                 core_err,
  input  wire logic                 sleep,
  input  wire logic                 xfer_en,
  input  wire logic                 xfer_read,
  input  wire logic                 sector_done,
  input  wire logic                 cmd_done,
  input  wire logic [27:0]          done_addr,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output atfr_pkg::atfr_word_t      rx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire atfr_pkg::atfr_word_t tx_data
);
  import atfr_pkg::*;

  atfr_byte_t feat_r, feat_nxt, scnt_r, scnt_nxt, snum_r, snum_nxt;
  atfr_byte_t cyll_r, cyll_nxt, cylh_r, cylh_nxt, dh_r, dh_nxt, code_r, code_nxt;
  atfr_word_t rdata_r, rdata_nxt;
  logic [8:0] left_r, left_nxt;
  logic       nien_r, nien_nxt, srst_r, srst_nxt, bsy_r, bsy_nxt;
  logic       cmdv_r, cmdv_nxt, drq_r, drq_nxt, intp_r, intp_nxt;
  logic       irq_r, irq_nxt, irq_oe_n_r, irq_oe_n_nxt;
  logic       bsy_now, tf_ok, rx_push, tx_pop, int_set, int_clr;
  logic       rxq_in_ready, txq_out_valid;
  atfr_word_t txq_data;

  // Status byte shared by status and shadow status reads
  function automatic atfr_byte_t status_byte(input logic bsy, input logic drq);
    status_byte              = 8'h00;
    status_byte[ST_BSY_BIT]  = bsy;
    status_byte[ST_DRDY_BIT] = core_drdy;
    status_byte[ST_DSC_BIT]  = core_dsc;
    status_byte[ST_DRQ_BIT]  = drq;
    status_byte[ST_ERR_BIT]  = core_err;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data path buffers: host writes into rx, core words out of tx
  atfr_buf #(.W(16), .DEPTH(2)) u_rxq (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (srst_r),
    .in_valid  (rx_push),
    .in_ready  (rxq_in_ready),
    .in_data   (bus.wdata),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  atfr_buf #(.W(16), .DEPTH(2)) u_txq (
    .clock     (clock),
    .nrst      (nrst),
    .flush     (srst_r),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (txq_out_valid),
    .out_ready (tx_pop),
    .out_data  (txq_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the register set
  always_comb begin
    feat_nxt = feat_r;
    scnt_nxt = scnt_r;
    snum_nxt = snum_r;
    cyll_nxt = cyll_r;
    cylh_nxt = cylh_r;
    dh_nxt   = dh_r;
    code_nxt = code_r;
    nien_nxt = nien_r;
    srst_nxt = srst_r;
    bsy_nxt  = bsy_r;
    rdata_nxt = rdata_r;
    cmdv_nxt = 1'b0;
    rx_push  = 1'b0;
    tx_pop   = 1'b0;
    int_clr  = 1'b0;
    bsy_now = bsy_r | srst_r | core_busy;
    tf_ok = !bsy_now && !drq_r;
    if (bus.wr_stb) begin
      case (bus.addr)
        ADR_FEAT: if (tf_ok) feat_nxt = bus.wdata[7:0];
        ADR_SCNT: if (tf_ok) scnt_nxt = bus.wdata[7:0];
        ADR_SNUM: if (tf_ok) snum_nxt = bus.wdata[7:0];
        ADR_CYLL: if (tf_ok) cyll_nxt = bus.wdata[7:0];
        ADR_CYLH: if (tf_ok) cylh_nxt = bus.wdata[7:0];
        ADR_DHS:  if (tf_ok) dh_nxt = bus.wdata[7:0];
        ADR_CMD: begin
          if (tf_ok) begin
            code_nxt = bus.wdata[7:0];
            cmdv_nxt = 1'b1;
            bsy_nxt  = 1'b1;
          end
        end
        ADR_CTL: begin
          if (bus.dmack_n) begin
            nien_nxt = bus.wdata[DC_NIEN_BIT];
            srst_nxt = bus.wdata[DC_SRST_BIT];
          end
        end
        ADR_DATA: rx_push = drq_r & !xfer_read & rxq_in_ready;
        default: ;
      endcase
    end
    if (bus.rd_stb) begin
      case (bus.addr)
        ADR_DATA: begin
          tx_pop    = drq_r & xfer_read & txq_out_valid;
          rdata_nxt = tx_pop ? txq_data : 16'h0000;
        end
        ADR_FEAT: rdata_nxt = {8'h00, feat_r};
        ADR_SCNT: rdata_nxt = {8'h00, scnt_r};
        ADR_SNUM: rdata_nxt = {8'h00, snum_r};
        ADR_CYLL: rdata_nxt = {8'h00, cyll_r};
        ADR_CYLH: rdata_nxt = {8'h00, cylh_r};
        ADR_DHS:  rdata_nxt = {8'h00, dh_r};
        ADR_CMD: begin
          rdata_nxt = {8'h00, status_byte(bsy_now, drq_r)};
          int_clr   = 1'b1;
        end
        ADR_CTL:  rdata_nxt = {8'h00, status_byte(bsy_now, drq_r)};
        default:  rdata_nxt = 16'h0000;
      endcase
      if (sleep && bus.addr != ADR_DATA) begin
        rdata_nxt = 16'h0000;
      end
    end
    if (sector_done) begin
      scnt_nxt = scnt_r - 8'h01;
    end
    if (cmd_done) begin
      snum_nxt = done_addr[7:0];
      cyll_nxt = done_addr[15:8];
      cylh_nxt = done_addr[23:16];
      dh_nxt   = {dh_r[7:4], done_addr[27:24]};
      bsy_nxt  = 1'b0;
    end
    if (srst_r) begin
      feat_nxt = FEAT_RST;
      scnt_nxt = SCNT_RST;
      snum_nxt = SNUM_RST;
      cyll_nxt = CYL_RST;
      cylh_nxt = CYL_RST;
      dh_nxt   = DH_RST;
      bsy_nxt  = 1'b0;
      cmdv_nxt = 1'b0;
      int_clr  = 1'b1;
    end
    left_nxt = (scnt_nxt == 8'h00) ? SCNT_ZERO_SECTORS : {1'b0, scnt_nxt};
    drq_nxt = xfer_en & !srst_nxt & (xfer_read ? txq_out_valid : rxq_in_ready);
    // mask drops pending and frees pin
    int_set      = cmd_done | sector_done;
    intp_nxt     = nien_nxt ? 1'b0 : (int_set | (intp_r & !int_clr));
    irq_nxt      = intp_nxt;
    irq_oe_n_nxt = nien_nxt;
  end

  // Register update
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      feat_r     <= FEAT_RST;
      scnt_r     <= SCNT_RST;
      snum_r     <= SNUM_RST;
      cyll_r     <= CYL_RST;
      cylh_r     <= CYL_RST;
      dh_r       <= DH_RST;
      code_r     <= 8'h00;
      nien_r     <= 1'b0;
      srst_r     <= 1'b0;
      bsy_r      <= 1'b0;
      rdata_r    <= 16'h0000;
      cmdv_r     <= 1'b0;
      drq_r      <= 1'b0;
      intp_r     <= 1'b0;
      irq_r      <= 1'b0;
      irq_oe_n_r <= 1'b0;
      left_r     <= {1'b0, SCNT_RST};
    end else begin
      feat_r     <= feat_nxt;
      scnt_r     <= scnt_nxt;
      snum_r     <= snum_nxt;
      cyll_r     <= cyll_nxt;
      cylh_r     <= cylh_nxt;
      dh_r       <= dh_nxt;
      code_r     <= code_nxt;
      nien_r     <= nien_nxt;
      srst_r     <= srst_nxt;
      bsy_r      <= bsy_nxt;
      rdata_r    <= rdata_nxt;
      cmdv_r     <= cmdv_nxt;
      drq_r      <= drq_nxt;
      intp_r     <= intp_nxt;
      irq_r      <= irq_nxt;
      irq_oe_n_r <= irq_oe_n_nxt;
      left_r     <= left_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers
  assign bus.rdata      = rdata_r;
  assign bus.intrq_o    = irq_r;
  assign bus.intrq_oe_n = irq_oe_n_r;
  assign cmd_valid      = cmdv_r;
  assign cmd_code       = code_r;
  assign feature        = feat_r;
  assign addr_mode      = atfr_amode_e'(dh_r[DH_LBA_BIT]);
  assign dev_sel        = dh_r[DH_DEV_BIT];
  assign head_or_lba_hi = dh_r[3:0];
  assign sector_num     = snum_r;
  assign cyl_low        = cyll_r;
  assign cyl_high       = cylh_r;
  assign sectors_left   = left_r;
  assign soft_reset     = srst_r;
endmodule

// ---- atfr_host.sv ----
// Host controller end: turns user register requests into port cycles and
// polls shadow status so that writes land only in their allowed windows.
// Assumes the drive answers a read strobe with data on the next cycle.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module atfr_host #(
  parameter int POLL_LIMIT = atfr_pkg::POLL_LIMIT_DEF
) (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  atfr_if.host                      bus,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic                 req_write,
  input  wire atfr_pkg::atfr_addr_t req_addr,
  input  wire atfr_pkg::atfr_word_t req_data,
  output logic                      rsp_valid,
  output logic                      rsp_err,
  output atfr_pkg::atfr_word_t      rsp_data,
  output logic                      host_irq
);
  import atfr_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_POLL, H_CHECK, H_ACCESS, H_RDATA} atfr_hst_e;

  atfr_hst_e  st_r, st_nxt;
  atfr_addr_t adr_r, adr_nxt;
  atfr_word_t dat_r, dat_nxt, rsp_r, rsp_nxt;
  logic [7:0] tries_r, tries_nxt;
  logic       wr_r, wr_nxt, wstb_r, wstb_nxt, rstb_r, rstb_nxt;
  logic       rdy_r, rdy_nxt, rv_r, rv_nxt, err_r, err_nxt, irq_r;
  logic       need_drq, need_idle, ok;

  // Request sequencing
  always_comb begin
    st_nxt    = st_r;
    adr_nxt   = adr_r;
    dat_nxt   = dat_r;
    wr_nxt    = wr_r;
    rsp_nxt   = rsp_r;
    tries_nxt = tries_r;
    wstb_nxt  = 1'b0;
    rstb_nxt  = 1'b0;
    rv_nxt    = 1'b0;
    err_nxt   = err_r;
    rdy_nxt   = rdy_r;
    need_drq  = (adr_r == ADR_DATA);
    need_idle = wr_r && adr_r != ADR_DATA && adr_r != ADR_CTL;
    ok = need_drq ? (!bus.rdata[ST_BSY_BIT] && bus.rdata[ST_DRQ_BIT])
                  : (!bus.rdata[ST_BSY_BIT] && !bus.rdata[ST_DRQ_BIT]);
    case (st_r)
      H_IDLE: begin
        rdy_nxt = 1'b1;
        if (req_valid && rdy_r) begin
          rdy_nxt   = 1'b0;
          adr_nxt   = req_addr;
          wr_nxt    = req_write;
          dat_nxt   = req_data;
          if (req_addr == ADR_CTL) begin
            dat_nxt = req_data & {8'h00, DCTL_MASK};
          end
          tries_nxt = 8'h00;
          st_nxt    = H_POLL;
        end
      end
      H_POLL: begin
        if (need_drq || need_idle) begin
          rstb_nxt = 1'b1;
          st_nxt   = H_CHECK;
        end else begin
          st_nxt = H_ACCESS;
        end
      end
      H_CHECK: begin
        if (rstb_r) begin
          st_nxt = H_CHECK;
        end else if (ok) begin
          st_nxt = H_ACCESS;
        end else if (tries_r == 8'(POLL_LIMIT)) begin
          rv_nxt  = 1'b1;
          err_nxt = 1'b1;
          st_nxt  = H_IDLE;
        end else begin
          tries_nxt = tries_r + 8'h01;
          st_nxt    = H_POLL;
        end
      end
      H_ACCESS: begin
        err_nxt  = 1'b0;
        wstb_nxt = wr_r;
        rstb_nxt = !wr_r;
        st_nxt   = H_RDATA;
      end
      H_RDATA: begin
        if (!(wstb_r || rstb_r)) begin
          rsp_nxt = wr_r ? dat_r : bus.rdata;
          rv_nxt  = 1'b1;
          st_nxt  = H_IDLE;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  // Register update
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r    <= H_IDLE;
      adr_r   <= ADR_DATA;
      dat_r   <= 16'h0000;
      wr_r    <= 1'b0;
      rsp_r   <= 16'h0000;
      tries_r <= 8'h00;
      wstb_r  <= 1'b0;
      rstb_r  <= 1'b0;
      rdy_r   <= 1'b0;
      rv_r    <= 1'b0;
      err_r   <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      adr_r   <= adr_nxt;
      dat_r   <= dat_nxt;
      wr_r    <= wr_nxt;
      rsp_r   <= rsp_nxt;
      tries_r <= tries_nxt;
      wstb_r  <= wstb_nxt;
      rstb_r  <= rstb_nxt;
      rdy_r   <= rdy_nxt;
      rv_r    <= rv_nxt;
      err_r   <= err_nxt;
      irq_r   <= bus.intrq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port and user outputs; status polls use the shadow address
  assign bus.addr    = (st_r == H_CHECK) ? ADR_CTL : adr_r;
  assign bus.wr_stb  = wstb_r;
  assign bus.rd_stb  = rstb_r;
  assign bus.wdata   = dat_r;
  assign bus.dmack_n = 1'b1;
  assign req_ready   = rdy_r;
  assign rsp_valid   = rv_r;
  assign rsp_err     = err_r;
  assign rsp_data    = rsp_r;
  assign host_irq    = irq_r;
endmodule

// ---- atfr_asserts.sv ----
// Checker of the host port signals between the host end and the drive end.
// Assumes the bench instantiates it beside the port interface instance.
`timescale 1ns/1ns
module atfr_asserts
  import atfr_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [3:0]  addr,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        dmack_n,
  input wire logic        intrq_o,
  input wire logic        intrq_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Control register writes, interrupt pin and register access seen on the port
  sequence s_ctl_wr;
    wr_stb && addr == ADR_CTL;
  endsequence
  property p_ctl_dmack;
    s_ctl_wr |-> dmack_n;
  endproperty
  a_ctl_dmack: assert property (p_ctl_dmack)
    else $error("control write with dma ack active");
  property p_ctl_rsv;
    s_ctl_wr |-> wdata[0] == 1'b0 && wdata[7:3] == 5'h00;
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv)
    else $error("reserved control bits written as one");
  property p_mask_pin;
    s_ctl_wr |=> intrq_oe_n == $past(wdata[DC_NIEN_BIT]);
  endproperty
  a_mask_pin: assert property (p_mask_pin)
    else $error("pin release does not follow mask bit");
  property p_mask_hold;
    !(wr_stb && addr == ADR_CTL) |=> $stable(intrq_oe_n);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("pin release changed without control write");
  property p_mask_clr;
    intrq_oe_n |-> !intrq_o;
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("interrupt pending while masked");
  property p_alt_keep;
    rd_stb && addr == ADR_CTL && intrq_o |=> intrq_o;
  endproperty
  a_alt_keep: assert property (p_alt_keep)
    else $error("shadow status read dropped interrupt");
  property p_tf_idle;
    wr_stb && addr inside {[4'h1:4'h7]} |-> !rdata[ST_BSY_BIT] && !rdata[ST_DRQ_BIT];
  endproperty
  a_tf_idle: assert property (p_tf_idle)
    else $error("task file write without idle status");
  property p_data_drq;
    wr_stb && addr == ADR_DATA |-> rdata[ST_DRQ_BIT];
  endproperty
  a_data_drq: assert property (p_data_drq)
    else $error("data write without data request");
  property p_hi_byte;
    rd_stb && addr != ADR_DATA |=> rdata[15:8] == 8'h00;
  endproperty
  a_hi_byte: assert property (p_hi_byte)
    else $error("byte register read with upper byte set");
endmodule

// ---- test_ata_task_file_registers.sv ----
// Bench joining host end and drive end over the port interface.
// Assumes a 25 MHz clock; core side of the drive is driven here.
`timescale 1ns/1ns
module test_ata_task_file_registers;
  import atfr_pkg::*;
  logic        clock, nrst, req_valid, req_ready, req_write, rsp_valid, rsp_err, host_irq;
  logic        cmd_valid, dev_sel, soft_reset, core_busy, xfer_en, xfer_read, sleep;
  logic        sector_done, cmd_done, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [3:0]  head_or_lba_hi;
  logic [8:0]  sectors_left;
  logic [27:0] done_addr;
  atfr_addr_t  req_addr;
  atfr_word_t  req_data, rsp_data, rx_data, tx_data;
  atfr_byte_t  cmd_code, sector_num, cyl_low, cyl_high, feature;
  atfr_amode_e addr_mode;
  atfr_word_t  rxq[$];
  int          error_cnt = 0, comparisons = 0, cmd_cnt = 0, cyc = 0;

  atfr_if bus();
  atfr_host #(.POLL_LIMIT(3)) u_atfr_host (.clock, .nrst, .bus(bus.host), .req_valid,
    .req_ready, .req_write, .req_addr, .req_data, .rsp_valid, .rsp_err, .rsp_data, .host_irq);
  atfr_dev u_atfr_dev (.clock, .nrst, .bus(bus.dev), .cmd_valid, .cmd_code, .feature,
    .addr_mode, .dev_sel, .head_or_lba_hi, .sector_num, .cyl_low, .cyl_high, .sectors_left,
    .soft_reset, .core_busy, .core_drdy(1'b1), .core_dsc(1'b1), .core_err(1'b0), .sleep,
    .xfer_en, .xfer_read, .sector_done, .cmd_done, .done_addr, .rx_valid, .rx_ready, .rx_data,
    .tx_valid, .tx_ready, .tx_data);
  atfr_asserts u_atfr_asserts (.clock, .nrst, .addr(bus.addr), .wr_stb(bus.wr_stb),
    .rd_stb(bus.rd_stb), .wdata(bus.wdata), .rdata(bus.rdata), .dmack_n(bus.dmack_n),
    .intrq_o(bus.intrq_o), .intrq_oe_n(bus.intrq_oe_n));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, monitors and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cmd_valid === 1'b1) cmd_cnt <= cmd_cnt + 1;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic req(input logic w, input atfr_addr_t a, input atfr_word_t d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    {req_valid, req_write, req_addr, req_data} = {1'b1, w, a, d};
    @(negedge clock);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    chk(n < 300, "no response");
  endtask
  task automatic pulse_sector;
    sector_done = 1'b1;
    @(negedge clock);
    sector_done = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  task tally_and_finish;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_status;
    req(0, ADR_CMD, 0); chk(rsp_data === 16'h0050, "status idle");
    req(0, ADR_CTL, 0); chk(rsp_data === 16'h0050, "shadow status idle");
    sleep = 1'b1;
    req(0, ADR_SNUM, 0); chk(rsp_data === 16'h0000, "sleep read");
    sleep = 1'b0;
  endtask
  task t_addr;
    req(1, ADR_DHS, 16'h00F5);
    chk(addr_mode === AM_LBA && dev_sel === 1'b1 && head_or_lba_hi === 4'h5, "lba sel");
    req(1, ADR_FEAT, 16'h005A); chk(feature === 8'h5A, "feature written");
    req(1, ADR_CYLL, 16'h0034);
    req(1, ADR_CYLH, 16'h0012);
    req(0, ADR_CYLL, 0); chk(rsp_data === 16'h0034 && cyl_low === 8'h34, "cyl low");
    req(0, ADR_CYLH, 0); chk(rsp_data === 16'h0012 && cyl_high === 8'h12, "cyl high");
    req(1, ADR_SCNT, 0); chk(sectors_left === SCNT_ZERO_SECTORS, "zero count");
    req(1, ADR_DHS, 16'h00A3);
    chk(addr_mode === AM_CHS && dev_sel === 1'b0 && head_or_lba_hi === 4'h3, "chs sel");
    core_busy = 1'b1;
    req(1, ADR_CYLL, 16'h0099); chk(rsp_err === 1'b1 && cyl_low === 8'h34, "busy write");
    core_busy = 1'b0;
  endtask
  task t_cmd;
    req(1, ADR_DHS, 16'h00E0);
    req(1, ADR_SCNT, 16'h0002);
    req(1, ADR_CMD, 16'h0020); chk(cmd_cnt == 1 && cmd_code === 8'h20, "command");
    req(1, ADR_SCNT, 16'h0005); chk(rsp_err === 1'b1, "write while owned");
    pulse_sector();
    pulse_sector();
    req(0, ADR_SCNT, 0); chk(rsp_data === 16'h0000, "count at end");
    {cmd_done, done_addr} = {1'b1, 28'hABCDEF1};
    @(negedge clock);
    cmd_done = 1'b0;
    repeat (2) @(negedge clock);
    chk(sector_num === 8'hF1 && cyl_low === 8'hDE && cyl_high === 8'hBC, "final addr");
    chk(head_or_lba_hi === 4'hA && host_irq === 1'b1, "final head");
  endtask
  task t_irq;
    req(0, ADR_CTL, 0); repeat (2) @(negedge clock);
    chk(host_irq === 1'b1, "shadow read kept irq");
    req(0, ADR_CMD, 0); repeat (2) @(negedge clock);
    chk(host_irq === 1'b0, "status read cleared irq");
    pulse_sector();
    req(1, ADR_CTL, 16'h0002); repeat (2) @(negedge clock);
    chk(bus.intrq_oe_n === 1'b1 && host_irq === 1'b0, "masked");
    req(1, ADR_CTL, 16'h00F9); repeat (2) @(negedge clock);
    chk(bus.intrq_oe_n === 1'b0 && host_irq === 1'b0 && soft_reset === 1'b0, "unmask");
  endtask
  task t_data;
    int n;
    {xfer_en, xfer_read, rx_ready} = 3'b100;
    req(1, ADR_DATA, 16'hA5C3); chk(rsp_err === 1'b0, "word one");
    req(1, ADR_DATA, 16'h5A3C); chk(rsp_err === 1'b0, "word two");
    req(1, ADR_DATA, 16'hFFFF); chk(rsp_err === 1'b1, "full buffer");
    rx_ready = 1'b1;
    repeat (4) @(negedge clock);
    chk(rxq.size() == 2 && rxq[0] === 16'hA5C3 && rxq[1] === 16'h5A3C, "words out");
    {xfer_read, tx_valid, tx_data} = {2'b11, 16'h1234};
    n = 0;
    while (tx_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    tx_valid = 1'b0;
    req(0, ADR_DATA, 0); chk(rsp_data === 16'h1234 && rsp_err === 1'b0, "word in");
    req(0, ADR_DATA, 0); chk(rsp_err === 1'b1, "empty read");
    xfer_en = 1'b0;
  endtask
  task t_srst;
    req(1, ADR_CTL, 16'h0004); chk(soft_reset === 1'b1, "reset held");
    req(1, ADR_SNUM, 16'h0077); chk(rsp_err === 1'b1, "busy in reset");
    req(1, ADR_CTL, 16'h0000);
    req(0, ADR_DHS, 0); chk(soft_reset === 1'b0 && rsp_data === 16'h00A0, "reinit");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst, req_valid, req_write, core_busy, xfer_en, xfer_read} = '0;
    {sector_done, cmd_done, rx_ready, tx_valid, sleep} = '0;
    {req_addr, req_data, tx_data, done_addr} = '0;
    repeat (16) @(negedge clock);
    nrst = 1'b1;
    t_status();
    t_addr();
    t_cmd();
    t_irq();
    t_data();
    t_srst();
    tally_and_finish();
  end
endmodule
